// ===== rtl/qdb4_pkg.sv
// Shared constants and types of the burst-of-four DDR static RAM port
package qdb4_pkg;

  // Default geometry
  localparam int ADDR_W_DEF  = 8;
  localparam int DATA_W_DEF  = 18;
  localparam int LANE_W_DEF  = 9;
  localparam int BURST_LEN   = 4;
  localparam int BEAT_W      = 2;

  // DLL lock and clock-stop timing
  localparam int LOCK_CYCLES = 1024;
  localparam int MCLK_NS     = 100;
  localparam int STOP_NS     = 30;
  localparam int STOP_CYC    = (STOP_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int STOP_MARGIN = 3;
  localparam int STOP_WIN    = STOP_CYC + STOP_MARGIN;
  localparam int IDLE_W      = 3;
  localparam int HB_DIV_W    = 4;

  // Reset values
  localparam logic K_EDGE_RST = 1'b1;

  typedef enum logic [1:0] {
    QDB4_DESEL,
    QDB4_READ,
    QDB4_WRITE
  } qdb4_op_e;

endpackage : qdb4_pkg

// ===== rtl/qdb4_sync.sv
// Two-stage synchroniser for levels entering a clock domain
`timescale 1ns/100ps
module qdb4_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Levels in and out
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } qdb4_sync_s;

  qdb4_sync_s st;
  qdb4_sync_s next_st;

  always_comb begin
    next_st.meta   = din;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.stable;

endmodule : qdb4_sync

// ===== rtl/qdb4_port.sv
// Burst-of-four separate-I/O DDR static RAM port with DLL lock tracking
`timescale 1ns/100ps
// Function
// R1: Commands never disturb the other port's burst
// R2: Started bursts always run all four beats
// R3: Read and write both high deselects
// R4: Inputs sampled on link edges, commands on K
// R5: Read select low starts a read
// R6: Read ignored right after a read
// R7: Read data follows the next K edge
// R8: Write select low, read high starts write
// R9: Write ignored right after a write
// R10: Write beats taken on four successive edges
// R11: One command moves four words from base
// R12: Mask sampled with each write beat
// R13: Masked lane keeps its stored contents
// R14: Controller may mask lanes freely per beat
// R15: Narrow variant masks four-bit nybble lanes
// R16: Controller holds DLL disabled during power-up
// R17: Controller waits lock cycles after enabling
// R18: DLL resets on disable or stopped clock
// R19: Controller resets DLL on frequency change
// R20: DLL-enable low disables the DLL
// R21: Output clocks delay read data launch
// R22: Output clocks tied high select input clocks
// R23: Read beats leave in ascending burst order
module qdb4_port #(
  parameter int ADDR_W      = qdb4_pkg::ADDR_W_DEF,
  parameter int DATA_W      = qdb4_pkg::DATA_W_DEF,
  parameter int LANE_W      = qdb4_pkg::LANE_W_DEF,
  parameter int LOCK_CYCLES = qdb4_pkg::LOCK_CYCLES
) (
  // System clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // DLL status toward the system
  output logic                   dllLocked,
  // Link clock, one edge per data beat, and its phase echo
  input  wire logic              linkClk,
  output logic                   echoClk,
  // Command pins
  input  wire logic              rdN,
  input  wire logic              wrN,
  input  wire logic [ADDR_W-1:0] syncAddrIn,
  // Write data pins
  input  wire logic [DATA_W-1:0] writeDataIn,
  input  wire logic [DATA_W/LANE_W-1:0] byteMaskN,
  // Read data pins
  output logic      [DATA_W-1:0] readDataOut,
  output logic                   readValid,
  // Clock control pins
  input  wire logic              doffN,
  input  wire logic              outClk,
  input  wire logic              outClkN
);

  localparam int LANES  = DATA_W / LANE_W;
  localparam int BEAT_W = qdb4_pkg::BEAT_W;
  localparam int MEM_AW = ADDR_W + BEAT_W;
  localparam int LCNT_W = $clog2(LOCK_CYCLES + 1);
  localparam int HB_W   = qdb4_pkg::HB_DIV_W;
  localparam int IDLE_W = qdb4_pkg::IDLE_W;
  localparam logic [BEAT_W-1:0] LAST_BEAT = BEAT_W'(qdb4_pkg::BURST_LEN - 1);
  localparam logic [LCNT_W-1:0] LOCK_END  = LCNT_W'(LOCK_CYCLES);
  localparam logic [IDLE_W-1:0] IDLE_END  = IDLE_W'(qdb4_pkg::STOP_WIN);

  // Link-domain state
  typedef struct packed {
    logic                 kEdge;
    qdb4_pkg::qdb4_op_e   prevOp;
    logic                 rdPend;
    logic [ADDR_W-1:0]    rdPendAddr;
    logic                 rdAct;
    logic [BEAT_W-1:0]    rdBeat;
    logic [ADDR_W-1:0]    rdAddr;
    logic                 wrPend;
    logic [ADDR_W-1:0]    wrPendAddr;
    logic                 wrAct;
    logic [BEAT_W-1:0]    wrBeat;
    logic [ADDR_W-1:0]    wrAddr;
    logic [DATA_W-1:0]    qStage;
    logic                 vStage;
    logic [DATA_W-1:0]    qOut;
    logic                 vOut;
    logic [LCNT_W-1:0]    lockCnt;
    logic                 dllRdy;
    logic [HB_W-1:0]      hbCnt;
  } qdb4_lnk_s;

  // System-domain state
  typedef struct packed {
    logic              hbLast;
    logic [IDLE_W-1:0] idleCnt;
    logic              clkStopped;
    logic              relock;
    logic              locked;
  } qdb4_sys_s;

  qdb4_lnk_s         lnk;
  qdb4_lnk_s         next_lnk;
  qdb4_sys_s         sys;
  qdb4_sys_s         next_sys;
  logic [DATA_W-1:0] mem [0:(1<<MEM_AW)-1];
  logic [DATA_W-1:0] wrOld;
  logic [DATA_W-1:0] wrMerged;
  logic [DATA_W-1:0] rdWord;
  logic [4:0]        lnkSync;
  logic [1:0]        sysSync;
  logic              linkRst;
  logic              doffSync;
  logic              stopSync;
  logic              outTied;
  logic              accRd;
  logic              accWr;
  logic              hbSync;
  logic              rdySync;

  // Crossings into the link domain: reset, pins and clock-stop flag
  qdb4_sync #(
    .WIDTH (5)
  ) u_lnk_sync (
    .clk  (linkClk),
    .rst  (1'b0),
    .din  ({sys_rst, doffN, sys.clkStopped, outClk, outClkN}),
    .dout (lnkSync)
  );

  assign linkRst  = lnkSync[4];
  assign doffSync = lnkSync[3];
  assign stopSync = lnkSync[2];
  assign outTied  = lnkSync[1] & lnkSync[0]; // R22

  // Crossings into the system domain: heartbeat and lock flag
  qdb4_sync #(
    .WIDTH (2)
  ) u_sys_sync (
    .clk  (mclk),
    .rst  (sys_rst),
    .din  ({lnk.hbCnt[HB_W-1], lnk.dllRdy}),
    .dout (sysSync)
  );

  assign hbSync  = sysSync[1];
  assign rdySync = sysSync[0];

  assign rdWord = mem[{lnk.rdAddr, lnk.rdBeat}];
  assign wrOld  = mem[{lnk.wrAddr, lnk.wrBeat}];

  // Per-lane merge keeps masked lanes at their stored value
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    assign wrMerged[l*LANE_W +: LANE_W] = byteMaskN[l] ?
      wrOld[l*LANE_W +: LANE_W] : // R13 R15
      writeDataIn[l*LANE_W +: LANE_W]; // R12 R14
  end

  // Link-domain next state
  always_comb begin
    next_lnk = lnk;
    accRd    = 1'b0;
    accWr    = 1'b0;
    next_lnk.kEdge = ~lnk.kEdge;
    next_lnk.hbCnt = lnk.hbCnt + 1'b1;

    // Lock counter restarts whenever the DLL is off or its clock stopped
    if (!doffSync || stopSync) begin
      next_lnk.lockCnt = '0; // R18 R20
      next_lnk.dllRdy  = 1'b0; // R18 R20
    end else if (lnk.lockCnt != LOCK_END) begin
      next_lnk.lockCnt = lnk.lockCnt + 1'b1; // R17 R19
    end else begin
      next_lnk.dllRdy = 1'b1;
    end

    // Commands only on K edges; previous op gates repeats
    if (lnk.kEdge && lnk.dllRdy) begin // R4
      if (!rdN && lnk.prevOp != qdb4_pkg::QDB4_READ) begin // R5 R6
        accRd = 1'b1;
      end else if (!wrN && lnk.prevOp != qdb4_pkg::QDB4_WRITE &&
                   (rdN || lnk.prevOp == qdb4_pkg::QDB4_READ)) begin // R8 R9
        accWr = 1'b1;
      end
      case ({accRd, accWr})
        2'b10:   next_lnk.prevOp = qdb4_pkg::QDB4_READ;
        2'b01:   next_lnk.prevOp = qdb4_pkg::QDB4_WRITE;
        default: next_lnk.prevOp = qdb4_pkg::QDB4_DESEL; // R3
      endcase
    end

    // Read engine: pending for one beat, then four beats
    if (lnk.rdAct) begin // R2
      next_lnk.rdBeat = lnk.rdBeat + 1'b1; // R23
      if (lnk.rdBeat == LAST_BEAT) begin
        next_lnk.rdAct = 1'b0;
      end
    end
    if (lnk.rdPend) begin // R1
      next_lnk.rdPend = 1'b0;
      next_lnk.rdAct  = 1'b1;
      next_lnk.rdBeat = '0;
      next_lnk.rdAddr = lnk.rdPendAddr; // R11
    end
    if (accRd) begin
      next_lnk.rdPend     = 1'b1;
      next_lnk.rdPendAddr = syncAddrIn;
    end

    // Write engine: same shape, data taken while active
    if (lnk.wrAct) begin // R2 R10
      next_lnk.wrBeat = lnk.wrBeat + 1'b1;
      if (lnk.wrBeat == LAST_BEAT) begin
        next_lnk.wrAct = 1'b0;
      end
    end
    if (lnk.wrPend) begin // R1
      next_lnk.wrPend = 1'b0;
      next_lnk.wrAct  = 1'b1;
      next_lnk.wrBeat = '0;
      next_lnk.wrAddr = lnk.wrPendAddr; // R11
    end
    if (accWr) begin
      next_lnk.wrPend     = 1'b1;
      next_lnk.wrPendAddr = syncAddrIn;
    end

    // Output registers; the output clocks add one beat of delay
    next_lnk.qStage = lnk.rdAct ? rdWord : '0; // R7
    next_lnk.vStage = lnk.rdAct;
    if (outTied) begin // R22
      next_lnk.qOut = next_lnk.qStage;
      next_lnk.vOut = next_lnk.vStage;
    end else begin
      next_lnk.qOut = lnk.qStage; // R21
      next_lnk.vOut = lnk.vStage;
    end
  end

  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      lnk       <= '0;
      lnk.kEdge <= qdb4_pkg::K_EDGE_RST;
    end else begin
      lnk <= next_lnk;
    end
  end

  // Array write, one merged word per active beat
  always_ff @(posedge linkClk) begin
    if (!linkRst && lnk.wrAct) begin
      mem[{lnk.wrAddr, lnk.wrBeat}] <= wrMerged; // R10 R12
    end
  end

  // System-domain next state: watch the heartbeat for a stopped clock
  always_comb begin
    next_sys = sys;
    next_sys.hbLast = hbSync;
    if (hbSync != sys.hbLast) begin
      next_sys.idleCnt = '0;
    end else if (sys.idleCnt != IDLE_END) begin
      next_sys.idleCnt = sys.idleCnt + 1'b1;
    end
    next_sys.clkStopped = (next_sys.idleCnt == IDLE_END); // R18
    // The lock flag is stale after a stop; hold off until it has dropped
    if (next_sys.clkStopped) begin
      next_sys.relock = 1'b1; // R18
    end else if (!rdySync) begin
      next_sys.relock = 1'b0;
    end
    next_sys.locked = rdySync && !next_sys.clkStopped && !next_sys.relock;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sys <= '0;
    end else begin
      sys <= next_sys;
    end
  end

  assign dllLocked   = sys.locked;
  assign echoClk     = lnk.kEdge;
  assign readDataOut = lnk.qOut;
  assign readValid   = lnk.vOut;

  chk_desel_both_high: assert property ( // R3
    @(posedge linkClk) disable iff (linkRst)
    lnk.kEdge && lnk.dllRdy && rdN && wrN
      |=> lnk.prevOp == qdb4_pkg::QDB4_DESEL && !lnk.rdPend && !lnk.wrPend)
    else $error("deselect cycle started an operation");

  chk_read_back_reject: assert property ( // R6
    @(posedge linkClk) disable iff (linkRst)
    lnk.kEdge && lnk.prevOp == qdb4_pkg::QDB4_READ |=> !lnk.rdPend)
    else $error("read accepted right after a read");

  chk_write_back_reject: assert property ( // R9
    @(posedge linkClk) disable iff (linkRst)
    lnk.kEdge && lnk.prevOp == qdb4_pkg::QDB4_WRITE |=> !lnk.wrPend)
    else $error("write accepted right after a write");

  chk_read_k_latency: assert property ( // R7
    @(posedge linkClk) disable iff (linkRst)
    accRd && outTied ##1 outTied[*2] |=> readValid[*4])
    else $error("read data not on the beats after the next K edge");

  chk_read_c_delay: assert property ( // R21
    @(posedge linkClk) disable iff (linkRst)
    accRd && !outTied ##1 !outTied[*3] |=> readValid[*4])
    else $error("delayed read data not one beat later");

  chk_write_four_beats: assert property ( // R10
    @(posedge linkClk) disable iff (linkRst)
    accWr |=> lnk.wrPend ##1 (lnk.wrAct && lnk.wrBeat == 2'h0)
      ##1 lnk.wrBeat == 2'h1 ##1 lnk.wrBeat == 2'h2
      ##1 (lnk.wrAct && lnk.wrBeat == 2'h3))
    else $error("write burst beats out of sequence");

  chk_read_burst_whole: assert property ( // R2
    @(posedge linkClk) disable iff (linkRst)
    $rose(lnk.rdAct) |-> lnk.rdAct[*4] ##1 !lnk.rdAct || lnk.rdBeat == 2'h0)
    else $error("read burst cut short");

  chk_ports_independent: assert property ( // R1
    @(posedge linkClk) disable iff (linkRst)
    accWr && lnk.rdAct |=> lnk.vStage && $stable(lnk.rdAddr))
    else $error("write command disturbed a read in progress");

  chk_dll_disable: assert property ( // R20
    @(posedge linkClk) disable iff (linkRst)
    !doffSync |=> lnk.lockCnt == '0 && !lnk.dllRdy ##1 !accRd && !accWr)
    else $error("DLL not held off while disabled");

  chk_stop_unlocks: assert property ( // R18
    @(posedge mclk) disable iff (sys_rst)
    sys.clkStopped |-> !dllLocked)
    else $error("lock reported with the link clock stopped");

  chk_relock_hold: assert property ( // R18
    @(posedge mclk) disable iff (sys_rst)
    sys.clkStopped |=> !dllLocked)
    else $error("lock reported before the DLL relocked");

  chk_read_beat_order: assert property ( // R23
    @(posedge linkClk) disable iff (linkRst)
    lnk.rdAct && lnk.rdBeat != LAST_BEAT
      |=> lnk.rdAct && lnk.rdBeat == $past(lnk.rdBeat) + 2'h1)
    else $error("read beats not in ascending order");

endmodule : qdb4_port

// ===== bench/qdb4_host.sv
// Host controller model: link clock, commands and write beats
`timescale 1ns/100ps
module qdb4_host (
  // Link clock control and phase
  input  wire logic   linkRun,
  output logic        linkClk,
  input  wire logic   echoClk,
  // Command and write pins
  output logic        rdN,
  output logic        wrN,
  output logic [7:0]  syncAddrIn,
  output logic [17:0] writeDataIn,
  output logic [1:0]  byteMaskN
);
  int cyc = 0;

  initial begin
    linkClk = 1'b0;
    rdN = 1'b1;
    wrN = 1'b1;
    syncAddrIn = 8'h00;
    writeDataIn = 18'h00000;
    byteMaskN = 2'h3;
  end

  always #7.5 if (linkRun) linkClk = ~linkClk;
  always @(posedge linkClk) cyc <= cyc + 1;

  // Command held for one link clock cycle, then released to deselect with the address inverted
  task automatic issue(input logic r, input logic w,
                       input logic [7:0] a, output int c);
    do begin
      @(posedge linkClk);
      #1;
    end while (echoClk !== 1'b1);
    rdN = r;
    wrN = w;
    syncAddrIn = a;
    c = cyc;
    @(posedge linkClk);
    #1;
    rdN = 1'b1;
    wrN = 1'b1;
    syncAddrIn = ~a;
  endtask : issue

  // Beats two to five cycles after the command, mask free per beat
  task automatic beats(input logic [71:0] d, input logic [7:0] m);
    for (int n = 0; n < 4; n++) begin
      @(posedge linkClk);
      #1;
      writeDataIn = d[18*n +: 18];
      byteMaskN = m[2*n +: 2];
    end
    @(posedge linkClk);
    #1;
    writeDataIn = ~writeDataIn;
    byteMaskN = 2'h3;
  endtask : beats

  task automatic wr_burst(input logic [7:0] a, input logic [71:0] d,
                          input logic [7:0] m, output int c);
    issue(1'b1, 1'b0, a, c);
    fork
      beats(d, m);
    join_none
  endtask : wr_burst
endmodule : qdb4_host

// ===== bench/testbench.sv
// Self-checking bench of the burst-of-four DDR static RAM port
`timescale 1ns/100ps
module testbench;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        linkRun = 1'b1;
  logic        doffN = 1'b0;
  logic        outClk = 1'b1;
  logic        outClkN = 1'b1;
  logic        dllLocked, linkClk, echoClk, rdN, wrN, readValid;
  logic [7:0]  syncAddrIn;
  logic [17:0] writeDataIn, readDataOut;
  logic [1:0]  byteMaskN;
  logic [71:0] mres;
  logic [17:0] rq[$];
  int          vq[$];
  int          mismatches = 0;
  int          compares = 0;
  int          c, c2;

  qdb4_port #(.LOCK_CYCLES(16)) DUT (.mclk, .sys_rst, .dllLocked,
    .linkClk, .echoClk, .rdN, .wrN, .syncAddrIn, .writeDataIn,
    .byteMaskN, .readDataOut, .readValid, .doffN, .outClk, .outClkN);
  qdb4_host host (.linkRun, .linkClk, .echoClk, .rdN, .wrN,
    .syncAddrIn, .writeDataIn, .byteMaskN);

  always #50 mclk = ~mclk;
  always @(posedge linkClk) if (readValid === 1'b1) begin
    rq.push_back(readDataOut);
    vq.push_back(host.cyc);
  end

  function automatic logic [71:0] pat(input logic [7:0] a,
                                      input logic [1:0] s);
    for (int n = 0; n < 4; n++) pat[18*n +: 18] = {a, s, 2'(n), 6'h2a};
  endfunction : pat

  task automatic chk(input string nm, input logic [17:0] e,
                     input logic [17:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic mwait(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : mwait

  task automatic wait_lock;
    for (int i = 0; i < 300 && dllLocked !== 1'b1; i++) @(posedge mclk);
    mwait(1);
    chk("dll locked", 18'h1, 18'(dllLocked));
  endtask : wait_lock

  task automatic rd(input logic [7:0] a);
    rq.delete();
    vq.delete();
    host.issue(1'b0, 1'b1, a, c);
  endtask : rd

  // Beats since the last clear: count, data and cycle of each
  task automatic expect_rd(input logic [143:0] e, input int lat, nb);
    repeat (16) @(posedge linkClk);
    chk("beat count", 18'(nb), 18'(rq.size()));
    for (int n = 0; n < nb; n++) begin
      chk("read beat", e[18*n +: 18], rq[n]);
      chk("beat cycle", 18'(c + lat + n), 18'(vq[n]));
    end
  endtask : expect_rd

  task automatic t_boot;
    mwait(2);
    chk("locked in reset", 18'h0, 18'(dllLocked));
    chk("valid in reset", 18'h0, 18'(readValid));
    sys_rst = 1'b0;
    doffN = 1'b1;
    wait_lock();
  endtask : t_boot

  task automatic t_wrrd;
    logic [7:0] m = 8'h46;
    host.wr_burst(8'h11, pat(8'h11, 2'h0), 8'h00, c);
    mwait(2);
    host.wr_burst(8'h22, pat(8'h22, 2'h0), 8'h00, c);
    mwait(2);
    rd(8'h11);
    expect_rd(pat(8'h11, 2'h0), 3, 4);
    host.wr_burst(8'h22, pat(8'h22, 2'h1), m, c);
    mwait(2);
    for (int i = 0; i < 8; i++)
      mres[9*i +: 9] = 9'(m[i] ? pat(8'h22, 2'h0) >> (9*i)
                               : pat(8'h22, 2'h1) >> (9*i));
    rd(8'h22);
    expect_rd(mres, 3, 4);
  endtask : t_wrrd

  task automatic t_refuse;
    rd(8'h11);
    host.issue(1'b0, 1'b1, 8'h22, c2);
    expect_rd(pat(8'h11, 2'h0), 3, 4);
    host.wr_burst(8'h33, pat(8'h33, 2'h2), 8'h00, c);
    host.issue(1'b1, 1'b0, 8'h11, c2);
    mwait(2);
    rq.delete();
    vq.delete();
    host.issue(1'b1, 1'b1, 8'h33, c);
    expect_rd(144'h0, 3, 0);
    host.issue(1'b0, 1'b0, 8'h11, c);
    expect_rd(pat(8'h11, 2'h0), 3, 4);
    rd(8'h33);
    expect_rd(pat(8'h33, 2'h2), 3, 4);
  endtask : t_refuse

  task automatic t_alt;
    rd(8'h11);
    host.wr_burst(8'h44, pat(8'h44, 2'h3), 8'h00, c2);
    host.issue(1'b0, 1'b1, 8'h22, c2);
    expect_rd({mres, pat(8'h11, 2'h0)}, 3, 8);
    mwait(1);
    outClk = 1'b0;
    mwait(3);
    rd(8'h44);
    expect_rd(pat(8'h44, 2'h3), 4, 4);
    mwait(1);
    outClk = 1'b1;
  endtask : t_alt

  task automatic t_dll;
    mwait(1);
    doffN = 1'b0;
    mwait(5);
    chk("locked with dll off", 18'h0, 18'(dllLocked));
    rd(8'h11);
    expect_rd(144'h0, 3, 0);
    mwait(1);
    doffN = 1'b1;
    wait_lock();
    linkRun = 1'b0;
    mwait(10);
    chk("locked with clock stopped", 18'h0, 18'(dllLocked));
    linkRun = 1'b1;
    wait_lock();
    rd(8'h11);
    expect_rd(pat(8'h11, 2'h0), 3, 4);
  endtask : t_dll

  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end

  initial begin
    t_boot();
    t_wrrd();
    t_refuse();
    t_alt();
    t_dll();
    print_verdict();
  end
endmodule : testbench
